/* core/dfp_inhibit_timer.sv */
// Purpose: Millisecond pacing for cyclic refresh of static read tasks.
// Assumes: run_in stays high for the whole static read task.
// Notes:   A period of zero gives a tick on every cycle.
`timescale 1ns/1ps

module dfp_inhibit_timer #(
  parameter int CYCLES_PER_MS = 20000
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        run_in,
  input  wire logic [15:0] period_ms_in,
  output logic             tick_out
);

  logic [31:0] cyc_r;
  logic [15:0] ms_r;
  logic        ms_end;

  assign ms_end   = (cyc_r == 32'(CYCLES_PER_MS - 1));
  assign tick_out = run_in &&
                    ((period_ms_in == 16'h0000) ||
                     (ms_end && (ms_r == period_ms_in - 16'h0001)));

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || !run_in || tick_out) begin
      cyc_r <= 32'h0000_0000;
      ms_r  <= 16'h0000;
    end else if (ms_end) begin
      cyc_r <= 32'h0000_0000;
      ms_r  <= ms_r + 16'h0001;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
    end
  end

endmodule // dfp_inhibit_timer

/* core/dfp_param_bank.sv */
// Purpose: Fieldbus parameter bank of a stepper drive: restore, user
//          reset, station address, process data mapping, read pacing
//          and fault responses.
// Assumes: One parameter access per request; inputs synchronous.
// Notes:   Reset stands for power-on; the station address is loaded from
//          nonvolatile storage in the first cycle after release.
// Behaviour
// - Write 1 starts restore; 0 does nothing.
// - Restore stores defaults; trigger reads 0 after.
// - Restored defaults act only after power-on.
// - User reset bit 0 defaults persistent parameters.
// - User reset keeps communication and motor settings.
// - User reset values never stored to memory.
// - Station address accepted only from 1 to 126.
// - New station address acts after power-on.
// - Process fault: mode error or class 1 error.
// - Wide inbound map selects listed 32-bit parameters.
// - Narrow map accepted only with 16-bit wide map.
// - Outbound map selects ramp parameters or none.
// - Static read refreshed every inhibit milliseconds.
// - Master clear or watchdog applies safe state.
`timescale 1ns/1ps
`include "dfp_regs.svh"

module dfp_param_bank #(
  parameter int CYCLES_PER_MS = `DFP_CYCLES_PER_MS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [15:0] param_addr_in,
  input  wire logic        param_wr_in,
  input  wire logic [31:0] param_wr_data_in,
  input  wire logic        param_rd_in,
  input  wire logic        param_static_in,
  output logic [31:0]      param_rd_data_out,
  output logic             param_rd_valid_out,
  output logic             param_wr_reject_out,
  input  wire logic [15:0] nvm_station_addr_in,
  input  wire logic        nvm_done_in,
  output logic             nvm_restore_req_out,
  output logic             user_defaults_out,
  output logic [15:0]      active_station_addr_out,
  output logic [31:0]      map_out_sel_out,
  output logic [31:0]      map_in_wide_sel_out,
  output logic [31:0]      map_in_narrow_sel_out,
  input  wire logic        pd_fault_in,
  input  wire logic        master_clear_in,
  input  wire logic        watchdog_expired_in,
  input  wire logic        power_stage_active_in,
  output logic             mode_error_out,
  output logic             error_class1_out,
  output logic             error_class2_out,
  output logic             fault_entry_out
);

  ////////////////////////////////////////////////////////////////////////
  // Value checks shared by writes and assertions.

  function automatic logic is_wide_sel(input logic [31:0] v);
    return v == `DFP_RST_MAP || v == `DFP_SEL_ERR_NUMBER ||
           v == `DFP_SEL_DIG_IO || v == `DFP_SEL_TEMP_STAGE ||
           v == `DFP_SEL_DC_BUS || v == `DFP_SEL_MOTOR_CURRENT ||
           v == `DFP_SEL_ACTION_WORD;
  endfunction

  // The error number stays a full 32-bit item; the others fit 16 bits.
  function automatic logic is_narrow_sel(input logic [31:0] v);
    return v == `DFP_SEL_DIG_IO || v == `DFP_SEL_TEMP_STAGE ||
           v == `DFP_SEL_DC_BUS || v == `DFP_SEL_MOTOR_CURRENT ||
           v == `DFP_SEL_ACTION_WORD;
  endfunction

  function automatic logic is_out_sel(input logic [31:0] v);
    return v == `DFP_RST_MAP || v == `DFP_SEL_ACCEL ||
           v == `DFP_SEL_DECEL || v == `DFP_SEL_SYM_RAMP;
  endfunction

  function automatic logic is_station(input logic [15:0] v);
    return v >= `DFP_STATION_MIN && v <= `DFP_STATION_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  dfp_pkg::dfp_store_state_t store_state_r;
  logic [15:0] station_r;
  logic [31:0] map_out_r;
  logic [31:0] map_in_wide_r;
  logic [31:0] map_in_narrow_r;
  logic [15:0] inhibit_r;
  logic [15:0] safe_state_r;
  logic [15:0] fault_resp_r;
  logic        por_done_r;
  logic        tick;
  logic        wr_ok;
  logic        hit_station;
  logic        hit_map_out;
  logic        hit_wide;
  logic        hit_narrow;
  logic        hit_inhibit;
  logic        hit_safe;
  logic        hit_fault;
  logic        hit_restore;
  logic        hit_user;
  logic        safe_event;

  assign hit_station = param_addr_in == `DFP_ADDR_STATION;
  assign hit_map_out = param_addr_in == `DFP_ADDR_MAP_OUT;
  assign hit_wide    = param_addr_in == `DFP_ADDR_MAP_IN_WIDE;
  assign hit_narrow  = param_addr_in == `DFP_ADDR_MAP_IN_NARROW;
  assign hit_inhibit = param_addr_in == `DFP_ADDR_INHIBIT;
  assign hit_safe    = param_addr_in == `DFP_ADDR_SAFE_STATE;
  assign hit_fault   = param_addr_in == `DFP_ADDR_FAULT_RESP;
  assign hit_restore = param_addr_in == `DFP_ADDR_FACTORY_RESTORE;
  assign hit_user    = param_addr_in == `DFP_ADDR_USER_RESET;
  assign safe_event  = master_clear_in || watchdog_expired_in;

  // Out-of-range values leave the register unchanged and are flagged.
  always_comb begin
    wr_ok = 1'b1;
    if (hit_station)
      wr_ok = is_station(param_wr_data_in[15:0]);
    else if (hit_wide)
      wr_ok = is_wide_sel(param_wr_data_in);
    else if (hit_narrow)
      wr_ok = is_narrow_sel(param_wr_data_in) &&
              is_narrow_sel(map_in_wide_r);
    else if (hit_map_out)
      wr_ok = is_out_sel(param_wr_data_in);
    else if (hit_safe || hit_fault)
      wr_ok = param_wr_data_in[31:1] == 31'h0000_0000;
    else if (hit_restore)
      wr_ok = param_wr_data_in[31:1] == 31'h0000_0000 &&
              store_state_r == dfp_pkg::DFP_STORE_IDLE;
    else if (!hit_inhibit && !hit_user)
      wr_ok = 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in)
      param_wr_reject_out <= 1'b0;
    else
      param_wr_reject_out <= param_wr_in && !wr_ok;
  end

  // The user reset touches only working storage of other banks; every
  // register here is a communication setting and so stays as it is.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in)
      user_defaults_out <= 1'b0;
    else
      user_defaults_out <= param_wr_in && hit_user &&
                           param_wr_data_in[`DFP_USER_RESET_BIT];
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      map_out_r       <= `DFP_RST_MAP;
      map_in_wide_r   <= `DFP_RST_MAP;
      map_in_narrow_r <= `DFP_RST_MAP;
      inhibit_r       <= `DFP_RST_INHIBIT;
      safe_state_r    <= `DFP_RST_SAFE_STATE;
      fault_resp_r    <= `DFP_RST_FAULT_RESP;
    end else if (param_wr_in && wr_ok) begin
      if (hit_map_out)
        map_out_r <= param_wr_data_in;
      if (hit_wide)
        map_in_wide_r <= param_wr_data_in;
      if (hit_narrow)
        map_in_narrow_r <= param_wr_data_in;
      if (hit_inhibit)
        inhibit_r <= param_wr_data_in[15:0];
      if (hit_safe)
        safe_state_r <= param_wr_data_in[15:0];
      if (hit_fault)
        fault_resp_r <= param_wr_data_in[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Station address: stored value is picked up once after power-on and
  // the active copy then holds until the next power-on.

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      por_done_r              <= 1'b0;
      station_r               <= `DFP_RST_STATION;
      active_station_addr_out <= `DFP_RST_STATION;
    end else if (!por_done_r) begin
      por_done_r <= 1'b1;
      if (is_station(nvm_station_addr_in)) begin
        station_r               <= nvm_station_addr_in;
        active_station_addr_out <= nvm_station_addr_in;
      end
    end else if (param_wr_in && wr_ok && hit_station) begin
      station_r <= param_wr_data_in[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Factory restore: the store runs in nonvolatile memory only, so the
  // working registers keep their values until the next power-on.

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      store_state_r <= dfp_pkg::DFP_STORE_IDLE;
    end else begin
      unique case (store_state_r)
        dfp_pkg::DFP_STORE_IDLE:
          if (param_wr_in && wr_ok && hit_restore && param_wr_data_in[0])
            store_state_r <= dfp_pkg::DFP_STORE_BUSY;
        dfp_pkg::DFP_STORE_BUSY:
          if (nvm_done_in)
            store_state_r <= dfp_pkg::DFP_STORE_IDLE;
      endcase
    end
  end

  assign nvm_restore_req_out = store_state_r == dfp_pkg::DFP_STORE_BUSY;

  ////////////////////////////////////////////////////////////////////////
  // Parameter channel reads, with cyclic refresh of static reads.

  dfp_inhibit_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_inhibit (
    .ref_clk_in   (ref_clk_in),
    .reset_n_in   (reset_n_in),
    .run_in       (param_static_in),
    .period_ms_in (inhibit_r),
    .tick_out     (tick)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      param_rd_valid_out <= 1'b0;
      param_rd_data_out  <= 32'h0000_0000;
    end else begin
      param_rd_valid_out <= param_rd_in || tick;
      if (param_rd_in || tick) begin
        unique case (1'b1)
          hit_station: param_rd_data_out <= {16'h0000, station_r};
          hit_map_out: param_rd_data_out <= map_out_r;
          hit_wide:    param_rd_data_out <= map_in_wide_r;
          hit_narrow:  param_rd_data_out <= map_in_narrow_r;
          hit_inhibit: param_rd_data_out <= {16'h0000, inhibit_r};
          hit_safe:    param_rd_data_out <= {16'h0000, safe_state_r};
          hit_fault:   param_rd_data_out <= {16'h0000, fault_resp_r};
          hit_restore:
            param_rd_data_out <= {31'h0000_0000,
                                  nvm_restore_req_out};
          default:     param_rd_data_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault responses.

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      mode_error_out   <= 1'b0;
      error_class1_out <= 1'b0;
    end else begin
      mode_error_out   <= pd_fault_in && !fault_resp_r[0];
      error_class1_out <= pd_fault_in && fault_resp_r[0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      error_class2_out <= 1'b0;
      fault_entry_out  <= 1'b0;
    end else begin
      error_class2_out <= safe_event && safe_state_r[0];
      fault_entry_out  <= safe_event && safe_state_r[0] &&
                          power_stage_active_in;
    end
  end

  assign map_out_sel_out       = map_out_r;
  assign map_in_wide_sel_out   = map_in_wide_r;
  assign map_in_narrow_sel_out = map_in_narrow_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_restore_go;
    param_wr_in && hit_restore && param_wr_data_in == 32'h0000_0001 &&
    !nvm_restore_req_out;
  endsequence

  sequence s_restore_busy_read;
    param_rd_in && hit_restore && nvm_restore_req_out && !nvm_done_in;
  endsequence

  property p_restore_start;
    s_restore_go |=> nvm_restore_req_out;
  endproperty
  a_restore_start: assert property (p_restore_start)
    else $error("restore did not start");

  property p_busy_read;
    s_restore_busy_read |=> param_rd_valid_out && param_rd_data_out != 0;
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("trigger read zero while storing");

  property p_done_read;
    param_rd_in && hit_restore && !nvm_restore_req_out
      |=> param_rd_data_out == 32'h0000_0000;
  endproperty
  a_done_read: assert property (p_done_read)
    else $error("trigger read nonzero when idle");

  property p_restore_keeps;
    nvm_restore_req_out && !param_wr_in |=> $stable(safe_state_r) &&
      $stable(map_out_r) && $stable(inhibit_r);
  endproperty
  a_restore_keeps: assert property (p_restore_keeps)
    else $error("restore changed working value");

  property p_station_range;
    por_done_r |-> is_station(station_r);
  endproperty
  a_station_range: assert property (p_station_range)
    else $error("station address out of range");

  property p_active_fixed;
    por_done_r |=> $stable(active_station_addr_out);
  endproperty
  a_active_fixed: assert property (p_active_fixed)
    else $error("active station address changed");

  property p_pd_fault;
    pd_fault_in |=> (error_class1_out == $past(fault_resp_r[0])) &&
      (mode_error_out != error_class1_out);
  endproperty
  a_pd_fault: assert property (p_pd_fault)
    else $error("wrong process fault response");

  property p_safe_state;
    safe_event && safe_state_r[0] && power_stage_active_in
      |=> error_class2_out && fault_entry_out;
  endproperty
  a_safe_state: assert property (p_safe_state)
    else $error("safe state not applied");

  property p_narrow_gate;
    param_wr_in && hit_narrow && !is_narrow_sel(map_in_wide_r)
      |=> $stable(map_in_narrow_r) && param_wr_reject_out;
  endproperty
  a_narrow_gate: assert property (p_narrow_gate)
    else $error("narrow map taken without 16-bit wide map");

  property p_static_zero;
    param_static_in && inhibit_r == 16'h0000 [*2] |=> param_rd_valid_out;
  endproperty
  a_static_zero: assert property (p_static_zero)
    else $error("static read not refreshed");

  property p_user_no_store;
    param_wr_in && hit_user && !nvm_restore_req_out
      |=> user_defaults_out == $past(param_wr_data_in[0]) &&
          !nvm_restore_req_out;
  endproperty
  a_user_no_store: assert property (p_user_no_store)
    else $error("user reset handled wrongly");

endmodule // dfp_param_bank

/* core/dfp_pkg.sv */
// Purpose: Types shared by the fieldbus parameter bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Constants live in dfp_regs.svh.
package dfp_pkg;

  typedef enum logic [0:0] {
    DFP_STORE_IDLE,
    DFP_STORE_BUSY
  } dfp_store_state_t;

  typedef logic [15:0] dfp_addr_t;
  typedef logic [31:0] dfp_word_t;

endpackage

/* core/dfp_regs.svh */
// Purpose: Parameter addresses, reset values and timing counts of the
//          fieldbus parameter bank.
// Assumes: Parameter addresses are indices on the parameter channel.
// Notes:   Definitions only.
`ifndef DFP_REGS_SVH
`define DFP_REGS_SVH

`define DFP_ADDR_USER_RESET      16'h0410
`define DFP_ADDR_FACTORY_RESTORE 16'h040c
`define DFP_ADDR_STATION         16'h1800
`define DFP_ADDR_MAP_OUT         16'h1804
`define DFP_ADDR_MAP_IN_WIDE     16'h1806
`define DFP_ADDR_INHIBIT         16'h1808
`define DFP_ADDR_SAFE_STATE      16'h180a
`define DFP_ADDR_FAULT_RESP      16'h180e
`define DFP_ADDR_MAP_IN_NARROW   16'h181e

`define DFP_RST_MAP              32'h0000_0000
`define DFP_RST_INHIBIT          16'h03e8
`define DFP_RST_SAFE_STATE       16'h0001
`define DFP_RST_FAULT_RESP       16'h0000
`define DFP_RST_STATION          16'h007e

`define DFP_STATION_MIN          16'h0001
`define DFP_STATION_MAX          16'h007e
`define DFP_USER_RESET_BIT       0

`define DFP_SEL_ERR_NUMBER       32'h0000_1c0a
`define DFP_SEL_DIG_IO           32'h0000_0802
`define DFP_SEL_TEMP_STAGE       32'h0000_1c20
`define DFP_SEL_DC_BUS           32'h0000_1c1e
`define DFP_SEL_MOTOR_CURRENT    32'h0000_1e28
`define DFP_SEL_ACTION_WORD      32'h0000_1c08
`define DFP_SEL_ACCEL            32'h0000_0614
`define DFP_SEL_DECEL            32'h0000_0616
`define DFP_SEL_SYM_RAMP         32'h0000_0602

`define DFP_CLK_PERIOD_NS        50
`define DFP_MS_TIME_NS           1000000
`define DFP_CYCLES_PER_MS        (`DFP_MS_TIME_NS / `DFP_CLK_PERIOD_NS)

`endif

/* dv/dfp_nvm_model.sv */
// Purpose: Nonvolatile store model behind the parameter bank.
// Assumes: A store request is a level held until done has been seen.
// Notes:   Latency is set per test to answer promptly or slowly.
`timescale 1ns/1ps

module dfp_nvm_model #(
  parameter logic [15:0] STORED_ADDR = 16'h0005
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        store_req_in,
  input  wire logic [7:0]  latency_in,
  output logic [15:0]      station_out,
  output logic             done_out
);
  logic [7:0] cnt_r;

  assign station_out = STORED_ADDR;

  // Done is one pulse; a request that lingers restarts the count and is acked again.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      cnt_r    <= 8'h00;
      done_out <= 1'b0;
    end else if (done_out) begin
      cnt_r    <= 8'h00;
      done_out <= 1'b0;
    end else if (store_req_in) begin
      if (cnt_r == latency_in) begin
        done_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // dfp_nvm_model

/* dv/tb_top.sv */
// Purpose: Self-checking bench of the fieldbus parameter bank.
// Assumes: Millisecond count shortened to 4 cycles.
// Notes:   Stored station address in the memory model is 5.
`timescale 1ns/1ps

module tb_top;
  logic        clk;
  logic        rst_n;
  logic [15:0] addr;
  logic        wr;
  logic [31:0] wdat;
  logic        rd;
  logic        stat;
  logic        pd, mc, wd, pw;
  logic [7:0]  lat;
  logic [31:0] rdata, mo, mw, mn;
  logic        rvalid, rej, nreq, ud, me, e1, e2, fe, ndone;
  logic [15:0] act, nst;
  logic        ud_seen;
  int          err_count, checked;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  dfp_param_bank #(.CYCLES_PER_MS(4)) i_dut (
    .ref_clk_in(clk), .reset_n_in(rst_n), .param_addr_in(addr),
    .param_wr_in(wr), .param_wr_data_in(wdat), .param_rd_in(rd),
    .param_static_in(stat), .param_rd_data_out(rdata),
    .param_rd_valid_out(rvalid), .param_wr_reject_out(rej),
    .nvm_station_addr_in(nst), .nvm_done_in(ndone),
    .nvm_restore_req_out(nreq), .user_defaults_out(ud),
    .active_station_addr_out(act), .map_out_sel_out(mo),
    .map_in_wide_sel_out(mw), .map_in_narrow_sel_out(mn),
    .pd_fault_in(pd), .master_clear_in(mc), .watchdog_expired_in(wd),
    .power_stage_active_in(pw), .mode_error_out(me),
    .error_class1_out(e1), .error_class2_out(e2), .fault_entry_out(fe)
  );

  dfp_nvm_model i_nvm (
    .ref_clk_in(clk), .reset_n_in(rst_n), .store_req_in(nreq),
    .latency_in(lat), .station_out(nst), .done_out(ndone)
  );

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reject and the user reset pulse are seen in the answer cycle.
  task automatic wrt(input logic [15:0] a, input logic [31:0] d,
                     input logic r);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
    ud_seen = ud;
    chk(32'(rej), 32'(r));
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(32'(rvalid), 32'h1);
    chk(rdata, e);
  endtask

  // Inputs are {fault, clear, watchdog, power}; outputs likewise four.
  task automatic ev(input logic [3:0] i, input logic [3:0] e);
    @(posedge clk);
    {pd, mc, wd, pw} <= i;
    @(posedge clk);
    {pd, mc, wd} <= 3'h0;
    @(negedge clk);
    chk(32'({me, e1, e2, fe}), 32'(e));
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    logic [15:0] a [9] = '{16'h1804, 16'h1806, 16'h1808, 16'h180a,
      16'h180e, 16'h181e, 16'h1800, 16'h040c, 16'h1802};
    logic [31:0] e [9] = '{32'h0, 32'h0, 32'h3e8, 32'h1, 32'h0, 32'h0,
      32'h5, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) rdc(a[i], e[i]);
    chk(32'(act), 32'h5);
    wrt(16'h1802, 32'h1, 1'b1);
  endtask

  task automatic t_restore;
    int n;
    wrt(16'h040c, 32'h2, 1'b1);
    wrt(16'h040c, 32'h0, 1'b0);
    chk(32'(nreq), 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lat <= k ? 8'h00 : 8'h14;
      wrt(16'h040c, 32'h1, 1'b0);
      chk(32'(nreq), 32'h1);
      if (k == 0) rdc(16'h040c, 32'h1);
      if (k == 0) wrt(16'h040c, 32'h1, 1'b1);
      n = 0;
      while (nreq === 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      if (n == 200) begin
        chk(32'h0, 32'h1);
        wrap_up;
      end
      rdc(16'h040c, 32'h0);
    end
    rdc(16'h1808, 32'h3e8);
  endtask

  task automatic t_station;
    wrt(16'h1800, 32'h0, 1'b1);
    wrt(16'h1800, 32'h7f, 1'b1);
    rdc(16'h1800, 32'h5);
    wrt(16'h1800, 32'h1, 1'b0);
    wrt(16'h1800, 32'h7e, 1'b0);
    rdc(16'h1800, 32'h7e);
    chk(32'(act), 32'h5);
  endtask

  task automatic t_maps;
    logic [31:0] v [4] = '{32'h614, 32'h616, 32'h602, 32'h0};
    logic [31:0] w [5] = '{32'h1c1e, 32'h1e28, 32'h1c08, 32'h1c20, 32'h0};
    wrt(16'h1806, 32'h1c0a, 1'b0);
    chk(mw, 32'h1c0a);
    wrt(16'h1806, 32'h1c0b, 1'b1);
    wrt(16'h181e, 32'h802, 1'b1);
    wrt(16'h1806, 32'h802, 1'b0);
    wrt(16'h181e, 32'h1c20, 1'b0);
    chk(mn, 32'h1c20);
    for (int i = 0; i < 5; i++) begin
      wrt(16'h1806, w[i], 1'b0);
      chk(mw, w[i]);
    end
    // With mapping off there is no 16-bit wide value, so narrow is refused.
    wrt(16'h181e, 32'h1c1e, 1'b1);
    chk(mn, 32'h1c20);
    for (int i = 0; i < 4; i++) begin
      wrt(16'h1804, v[i], 1'b0);
      chk(mo, v[i]);
    end
    wrt(16'h1804, 32'h615, 1'b1);
    chk(mo, 32'h0);
  endtask

  task automatic t_faults;
    ev(4'h8, 4'h8);
    wrt(16'h180e, 32'h2, 1'b1);
    wrt(16'h180e, 32'h1, 1'b0);
    ev(4'h8, 4'h4);
    ev(4'h4, 4'h2);
    ev(4'h3, 4'h3);
    wrt(16'h180a, 32'h0, 1'b0);
    ev(4'h6, 4'h0);
  endtask

  task automatic t_static;
    int n;
    wrt(16'h1808, 32'h0, 1'b0);
    @(posedge clk);
    addr <= 16'h1808;
    stat <= 1'b1;
    @(posedge clk);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += (rvalid === 1'b1);
    end
    chk(n, 8);
    @(posedge clk);
    stat <= 1'b0;
    wrt(16'h1808, 32'h1, 1'b0);
    @(posedge clk);
    stat <= 1'b1;
    n = 0;
    repeat (2) begin
      @(negedge clk);
      n += (rvalid === 1'b1);
    end
    chk(n, 0);
    repeat (16) begin
      @(negedge clk);
      n += (rvalid === 1'b1);
    end
    chk(n, 4);
    chk(rdata, 32'h1);
    @(posedge clk);
    stat <= 1'b0;
  endtask

  task automatic t_user_reset;
    wrt(16'h0410, 32'h1, 1'b0);
    chk(32'(ud_seen), 32'h1);
    chk(32'(nreq), 32'h0);
    rdc(16'h1800, 32'h7e);
    rdc(16'h1808, 32'h1);
    wrt(16'h0410, 32'h0, 1'b0);
    chk(32'(ud_seen), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checked = 0;
    rst_n = 1'b0;
    addr = 16'h0;
    wdat = 32'h0;
    {wr, rd, stat, pd, mc, wd, pw} = 7'h0;
    lat = 8'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_values;
    t_restore;
    t_station;
    t_maps;
    t_faults;
    t_static;
    t_user_reset;
    wrap_up;
  end
endmodule // tb_top
